//--- src/epi_pkg.sv
// Purpose: Shared constants and types of the external pin interrupt unit.
// Assumes: 32-bit AXI4-Lite register access, one clock.
// Notes:   Register indices are scaled by four to give byte addresses.
package epi_pkg;

   localparam int NPINS = 16;

   // Register indices; byte address is four times the index.
   localparam logic [5:0] IDX_CTRL    = 6'h00;
   localparam logic [5:0] IDX_STATUS  = 6'h01;
   localparam logic [5:0] IDX_NMICFG  = 6'h02;
   localparam logic [5:0] IDX_NMIFLG  = 6'h03;
   localparam logic [5:0] IDX_EVCTL   = 6'h04;
   localparam logic [5:0] IDX_IENCLR  = 6'h08;
   localparam logic [5:0] IDX_IENSET  = 6'h0c;
   localparam logic [5:0] IDX_FLAGS   = 6'h10;
   localparam logic [5:0] IDX_WAKE    = 6'h14;
   localparam logic [5:0] IDX_CFG0    = 6'h18;
   localparam logic [5:0] IDX_CFG1    = 6'h1c;

   // Field positions.
   localparam int CTRL_SRST_BIT   = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam int STATUS_BUSY_BIT = 7;
   localparam int NMI_FILT_BIT    = 3;
   localparam int CFG_PINS_WORD   = 8;
   localparam int CFG_FIELD_W     = 4;

   // Reset values.
   localparam logic [15:0] RST_PINS = 16'h0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0]  RST_NMI  = 4'h0;

   // Sense selector codes.
   localparam logic [2:0] SENSE_NONE = 3'h0;
   localparam logic [2:0] SENSE_RISE = 3'h1;
   localparam logic [2:0] SENSE_FALL = 3'h2;
   localparam logic [2:0] SENSE_BOTH = 3'h3;
   localparam logic [2:0] SENSE_HIGH = 3'h4;
   localparam logic [2:0] SENSE_LOW  = 3'h5;

   // Timing: cycles of the control-domain transfer, and worst-case
   // latency of level detection without filter in bus clocks.
   localparam logic [1:0] SYNC_CYCLES   = 2'h2;
   localparam int         LEVEL_LAT_CYC = 3;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       filt;
      logic [2:0] sense;
   } epi_pin_cfg_t;

   typedef struct packed {
      logic       busy;
      logic [1:0] cnt;
      logic       en;
      logic       srst;
   } epi_sync_t;

endpackage

//--- src/epi_top.sv
// Purpose: External pin interrupt unit with AXI4-Lite register access.
// Assumes: Pins are synchronous to MCLK; the detect clock is MCLK too.
// Notes:   All outputs are registered.
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module epi_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   input  wire logic [15:0]       PIN_IN,
   input  wire logic              NMI_PIN,
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   output logic                   IRQ,
   output logic                   NMI_IRQ,
   output logic [15:0]            EVENT,
   output logic                   WAKE,
   output logic                   DETECT_CLK_REQ
);

   function automatic logic addr_known(input logic [5:0] idx);
      unique case (idx)
         epi_pkg::IDX_CTRL, epi_pkg::IDX_STATUS, epi_pkg::IDX_NMICFG,
         epi_pkg::IDX_NMIFLG, epi_pkg::IDX_EVCTL, epi_pkg::IDX_IENCLR,
         epi_pkg::IDX_IENSET, epi_pkg::IDX_FLAGS, epi_pkg::IDX_WAKE,
         epi_pkg::IDX_CFG0, epi_pkg::IDX_CFG1: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction

   function automatic logic majority(input logic [2:0] s);
      majority = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction

   function automatic logic sense_hit(input logic [2:0] sense,
                                      input logic       cur,
                                      input logic       prev);
      unique case (sense)
         epi_pkg::SENSE_RISE: sense_hit = cur & ~prev;
         epi_pkg::SENSE_FALL: sense_hit = ~cur & prev;
         epi_pkg::SENSE_BOTH: sense_hit = cur ^ prev;
         epi_pkg::SENSE_HIGH: sense_hit = cur;
         epi_pkg::SENSE_LOW:  sense_hit = ~cur;
         default:             sense_hit = 1'b0;
      endcase
   endfunction

   function automatic logic is_edge(input logic [2:0] sense);
      is_edge = (sense == epi_pkg::SENSE_RISE) ||
                (sense == epi_pkg::SENSE_FALL) ||
                (sense == epi_pkg::SENSE_BOTH);
   endfunction

   // Register state.
   logic              enable_q;
   logic [15:0]       evctl_q;
   logic [15:0]       inten_q;
   logic [15:0]       flag_q;
   logic [15:0]       wake_en_q;
   logic [31:0]       cfg_q [0:1];
   logic [3:0]        nmi_cfg_q;
   logic              nmi_flag_q;
   epi_pkg::epi_sync_t sync_q;
   logic              srst_go;

   // Bus slave state.
   logic              aw_full_q;
   logic              w_full_q;
   logic [5:0]        aw_idx_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic [5:0]        ar_idx;
   logic [31:0]       wmask;
   logic              wr_go;
   logic              wr_ctrl;
   logic              wr_ok;
   logic              locked;

   // Detection.
   logic [15:0]       det;
   logic [15:0]       det_prev_q;
   logic [15:0]       need_clk;
   logic [2:0]        nmi_smp_q;
   logic              nmi_prev_q;
   logic              nmi_sig;
   logic              nmi_det;
   epi_pkg::epi_pin_cfg_t nmi_cfg;

   assign srst_go = sync_q.busy && sync_q.cnt == 2'h1 && sync_q.srst;
   assign wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                     {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_ctrl = aw_idx_q == epi_pkg::IDX_CTRL;
   // A control write arriving while a transfer is pending waits here,
   // holding the bus until the earlier transfer has landed.
   assign wr_go   = aw_full_q && w_full_q && !S_AXI_BVALID &&
                    !(wr_ctrl && sync_q.busy);
   assign wr_ok   = wr_go && addr_known(aw_idx_q);
   assign locked  = enable_q;
   assign ar_idx  = S_AXI_ARADDR[7:2];

   // Write address and data are taken in either order.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_AWREADY <= 1'b1;
         aw_full_q     <= 1'b0;
         aw_idx_q      <= 6'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         S_AXI_AWREADY <= 1'b0;
         aw_full_q     <= 1'b1;
         aw_idx_q      <= S_AXI_AWADDR[7:2];
      end else if (wr_go) begin
         aw_full_q     <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_AWREADY <= 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_WREADY <= 1'b1;
         w_full_q     <= 1'b0;
         wdata_q      <= epi_pkg::RST_WORD;
         wstrb_q      <= 4'h0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         S_AXI_WREADY <= 1'b0;
         w_full_q     <= 1'b1;
         wdata_q      <= S_AXI_WDATA;
         wstrb_q      <= S_AXI_WSTRB;
      end else if (wr_go) begin
         w_full_q     <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_WREADY <= 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= epi_pkg::RESP_OKAY;
      end else if (wr_go) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= wr_ok ? epi_pkg::RESP_OKAY
                               : epi_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // Control transfer into the detect side: busy rises at once.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         sync_q <= '0;
      end else if (wr_ok && wr_ctrl && wstrb_q[0]) begin
         sync_q.busy <= 1'b1;
         sync_q.cnt  <= epi_pkg::SYNC_CYCLES;
         sync_q.en   <= wdata_q[epi_pkg::CTRL_ENABLE_BIT];
         sync_q.srst <= wdata_q[epi_pkg::CTRL_SRST_BIT];
      end else if (sync_q.busy) begin
         sync_q.cnt <= sync_q.cnt - 2'h1;
         if (sync_q.cnt == 2'h1) begin
            sync_q <= '0;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         enable_q <= 1'b0;
      end else if (srst_go) begin
         enable_q <= 1'b0;
      end else if (sync_q.busy && sync_q.cnt == 2'h1) begin
         enable_q <= sync_q.en;
      end
   end

   // Enable-protected configuration.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         evctl_q   <= epi_pkg::RST_PINS;
         wake_en_q <= epi_pkg::RST_PINS;
         cfg_q[0]  <= epi_pkg::RST_WORD;
         cfg_q[1]  <= epi_pkg::RST_WORD;
         nmi_cfg_q <= epi_pkg::RST_NMI;
      end else if (srst_go) begin
         evctl_q   <= epi_pkg::RST_PINS;
         wake_en_q <= epi_pkg::RST_PINS;
         cfg_q[0]  <= epi_pkg::RST_WORD;
         cfg_q[1]  <= epi_pkg::RST_WORD;
         nmi_cfg_q <= epi_pkg::RST_NMI;
      end else if (wr_ok && !locked) begin
         unique case (aw_idx_q)
            epi_pkg::IDX_EVCTL:
               evctl_q <= (evctl_q & ~wmask[15:0]) |
                          (wdata_q[15:0] & wmask[15:0]);
            epi_pkg::IDX_WAKE:
               wake_en_q <= (wake_en_q & ~wmask[15:0]) |
                            (wdata_q[15:0] & wmask[15:0]);
            epi_pkg::IDX_CFG0:
               cfg_q[0] <= (cfg_q[0] & ~wmask) | (wdata_q & wmask);
            epi_pkg::IDX_CFG1:
               cfg_q[1] <= (cfg_q[1] & ~wmask) | (wdata_q & wmask);
            epi_pkg::IDX_NMICFG:
               if (wstrb_q[0]) begin
                  nmi_cfg_q <= wdata_q[3:0];
               end
            default: ;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         inten_q <= epi_pkg::RST_PINS;
      end else if (srst_go) begin
         inten_q <= epi_pkg::RST_PINS;
      end else if (wr_ok && aw_idx_q == epi_pkg::IDX_IENSET) begin
         inten_q <= inten_q | (wdata_q[15:0] & wmask[15:0]);
      end else if (wr_ok && aw_idx_q == epi_pkg::IDX_IENCLR) begin
         inten_q <= inten_q & ~(wdata_q[15:0] & wmask[15:0]);
      end
   end

   // Flags: a detection in the clearing cycle wins over the clear.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         flag_q <= epi_pkg::RST_PINS;
      end else if (srst_go) begin
         flag_q <= epi_pkg::RST_PINS;
      end else if (wr_ok && aw_idx_q == epi_pkg::IDX_FLAGS) begin
         flag_q <= (flag_q & ~(wdata_q[15:0] & wmask[15:0])) | det;
      end else begin
         flag_q <= flag_q | det;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         nmi_flag_q <= 1'b0;
      end else if (srst_go) begin
         nmi_flag_q <= 1'b0;
      end else if (wr_ok && aw_idx_q == epi_pkg::IDX_NMIFLG &&
                   wstrb_q[0] && wdata_q[0]) begin
         nmi_flag_q <= nmi_det;
      end else begin
         nmi_flag_q <= nmi_flag_q | nmi_det;
      end
   end

   // Pin detection.
   generate
      for (genvar g = 0; g < epi_pkg::NPINS; g++) begin : g_pin
         epi_pkg::epi_pin_cfg_t pcfg;
         logic [2:0]            smp_q;
         logic                  prev_q;
         logic                  sig;

         assign pcfg = epi_pkg::epi_pin_cfg_t'(
            cfg_q[g / epi_pkg::CFG_PINS_WORD]
                 [epi_pkg::CFG_FIELD_W * (g % epi_pkg::CFG_PINS_WORD)
                  +: epi_pkg::CFG_FIELD_W]);
         // An unfiltered pin is looked at directly, so level detection
         // costs only the flag and output stages.
         assign sig = pcfg.filt ? majority(smp_q) : PIN_IN[g];
         assign det[g] = enable_q &&
                         sense_hit(pcfg.sense, sig, prev_q);
         assign need_clk[g] = pcfg.filt || is_edge(pcfg.sense);

         always_ff @(posedge MCLK or negedge RST_N) begin
            if (!RST_N) begin
               smp_q  <= 3'h0;
               prev_q <= 1'b0;
            end else begin
               smp_q  <= {smp_q[1:0], PIN_IN[g]};
               prev_q <= sig;
            end
         end
      end
   endgenerate

   // Nonmaskable detection ignores the unit enable.
   assign nmi_cfg = epi_pkg::epi_pin_cfg_t'(nmi_cfg_q);
   assign nmi_sig = nmi_cfg.filt ? majority(nmi_smp_q) : NMI_PIN;
   assign nmi_det = sense_hit(nmi_cfg.sense, nmi_sig, nmi_prev_q);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         nmi_smp_q  <= 3'h0;
         nmi_prev_q <= 1'b0;
      end else begin
         nmi_smp_q  <= {nmi_smp_q[1:0], NMI_PIN};
         nmi_prev_q <= nmi_sig;
      end
   end

   // Outputs.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ            <= 1'b0;
         NMI_IRQ        <= 1'b0;
         EVENT          <= 16'h0000;
         WAKE           <= 1'b0;
         DETECT_CLK_REQ <= 1'b0;
         det_prev_q     <= 16'h0000;
      end else begin
         IRQ     <= |(flag_q & inten_q);
         NMI_IRQ <= nmi_flag_q;
         // A held level gives one pulse, not a stream of them.
         EVENT      <= evctl_q & det & ~det_prev_q;
         det_prev_q <= det;
         WAKE       <= |(wake_en_q & det);
         DETECT_CLK_REQ <= (enable_q && |need_clk) ||
                           nmi_cfg.filt ||
                           is_edge(nmi_cfg.sense);
      end
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= epi_pkg::RST_WORD;
         S_AXI_RRESP   <= epi_pkg::RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RRESP   <= addr_known(ar_idx) ? epi_pkg::RESP_OKAY
                                             : epi_pkg::RESP_SLVERR;
         S_AXI_RDATA   <= epi_pkg::RST_WORD;
         unique case (ar_idx)
            epi_pkg::IDX_CTRL: begin
               S_AXI_RDATA[epi_pkg::CTRL_ENABLE_BIT] <= enable_q;
               S_AXI_RDATA[epi_pkg::CTRL_SRST_BIT]   <= sync_q.srst;
            end
            epi_pkg::IDX_STATUS:
               S_AXI_RDATA[epi_pkg::STATUS_BUSY_BIT] <= sync_q.busy;
            epi_pkg::IDX_NMICFG: S_AXI_RDATA[3:0]  <= nmi_cfg_q;
            epi_pkg::IDX_NMIFLG: S_AXI_RDATA[0]    <= nmi_flag_q;
            epi_pkg::IDX_EVCTL:  S_AXI_RDATA[15:0] <= evctl_q;
            epi_pkg::IDX_IENCLR,
            epi_pkg::IDX_IENSET: S_AXI_RDATA[15:0] <= inten_q;
            epi_pkg::IDX_FLAGS:  S_AXI_RDATA[15:0] <= flag_q;
            epi_pkg::IDX_WAKE:   S_AXI_RDATA[15:0] <= wake_en_q;
            epi_pkg::IDX_CFG0:   S_AXI_RDATA       <= cfg_q[0];
            epi_pkg::IDX_CFG1:   S_AXI_RDATA       <= cfg_q[1];
            default: ;
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

endmodule

//--- dv/epi_top_properties.sv
// Purpose: Port-level checks of the external pin interrupt unit.
// Assumes: One clock MCLK; RST_N asynchronous and active low.
// Notes:   A write-age counter ties every drop of IRQ or NMI_IRQ to a recent write.
`timescale 1ns/1ps
module epi_top_properties (
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic        IRQ,
   input wire logic        NMI_IRQ,
   input wire logic [15:0] EVENT
);
   logic [3:0] wr_age_q;

   // Saturates, so a long quiet spell never wraps back to recent.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N)
         wr_age_q <= 4'h0;
      else if (S_AXI_WVALID && S_AXI_WREADY)
         wr_age_q <= 4'h0;
      else if (wr_age_q != 4'hf)
         wr_age_q <= wr_age_q + 4'h1;
   end

   default clocking dc @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   sequence s_wr_both;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_b_taken;
      S_AXI_BVALID && S_AXI_BREADY;
   endsequence
   sequence s_r_taken;
      S_AXI_RVALID && S_AXI_RREADY;
   endsequence

   a_write_answer: assert property (
      s_wr_both |-> ##[1:4] S_AXI_BVALID)
      else $error("write response missing");
   a_ready_gap: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted while response pending");
   a_write_release: assert property (
      s_b_taken |=> !S_AXI_BVALID && S_AXI_AWREADY)
      else $error("write channel not released");
   a_read_answer: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   a_read_release: assert property (
      s_r_taken |=> !S_AXI_RVALID && S_AXI_ARREADY)
      else $error("read channel not released");
   a_irq_holds: assert property ($fell(IRQ) |-> wr_age_q < 4'ha)
      else $error("request dropped without a write");
   a_nmi_holds: assert property ($fell(NMI_IRQ) |-> wr_age_q < 4'ha)
      else $error("nonmaskable request dropped without a write");
   a_event_single: assert property (
      |EVENT |=> (EVENT & $past(EVENT)) == 16'h0)
      else $error("event longer than one cycle");
endmodule

bind epi_top epi_top_properties chk_u (
   .MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ), .NMI_IRQ(NMI_IRQ),
   .EVENT(EVENT));

//--- dv/epi_far_side.sv
// Purpose: Far-side model: drives the pins and counts event pulses.
// Assumes: Pins are synchronous to the clock and move just after an edge.
// Notes:   The bench clears the counts once, before the level batch of t_pins.
`timescale 1ns/1ps
module epi_far_side (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [15:0] event_in,
   output logic [15:0]      pins,
   output logic             nmi_pin
);
   int ev_cnt [16];

   initial begin
      pins = 16'h0000;
      nmi_pin = 1'b0;
   end

   task automatic drive(input logic [15:0] p, input logic n);
      pins <= p;
      nmi_pin <= n;
   endtask

   task automatic clear_counts;
      foreach (ev_cnt[i]) ev_cnt[i] = 0;
   endtask

   // Counting per cycle shows whether one condition gave one pulse.
   always @(posedge mclk) begin
      if (rst_n) begin
         foreach (ev_cnt[i]) if (event_in[i] === 1'b1) ev_cnt[i]++;
      end
   end
endmodule

//--- dv/test_external_pin_interrupt_unit.sv
// Purpose: Self-checking bench of the external pin interrupt unit.
// Assumes: AXI4-Lite master with response ready held high throughout.
// Notes:   Expected values follow from sense codes and register layout.
`timescale 1ns/1ps
module test_external_pin_interrupt_unit;
   logic        mclk, rst_n, awvalid, awready, wvalid, wready, bvalid;
   logic        arvalid, arready, rvalid, irq, nmi_irq, wake, det_req;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] ev, pins;
   logic        nmi_pin;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cyc = 0;

   epi_top dut_u (
      .MCLK(mclk), .RST_N(rst_n), .PIN_IN(pins), .NMI_PIN(nmi_pin),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(1'b1), .IRQ(irq), .NMI_IRQ(nmi_irq), .EVENT(ev),
      .WAKE(wake), .DETECT_CLK_REQ(det_req));

   epi_far_side far_u (
      .mclk(mclk), .rst_n(rst_n), .event_in(ev), .pins(pins),
      .nmi_pin(nmi_pin));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic test_done;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         test_done;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wr(input logic [5:0] i, input logic [31:0] d,
                     input logic [1:0] er = epi_pkg::RESP_OKAY);
      int n;
      n = 0;
      awaddr <= {i, 2'h0};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 40);
      chk({31'h0, bvalid}, 32'h1);
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rc(input logic [5:0] i, input logic [31:0] e,
                     input logic [1:0] er = epi_pkg::RESP_OKAY);
      int n;
      n = 0;
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 40);
      chk({31'h0, rvalid}, 32'h1);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask

   task automatic t_zero;
      logic [5:0] idx [10];
      idx = '{epi_pkg::IDX_CTRL, epi_pkg::IDX_NMICFG, epi_pkg::IDX_EVCTL,
              epi_pkg::IDX_IENSET, epi_pkg::IDX_FLAGS, epi_pkg::IDX_WAKE,
              epi_pkg::IDX_CFG0, epi_pkg::IDX_CFG1, epi_pkg::IDX_STATUS,
              epi_pkg::IDX_NMIFLG};
      foreach (idx[i]) rc(idx[i], epi_pkg::RST_WORD);
      chk({31'h0, det_req}, 32'h0);
   endtask

   task automatic t_regs;
      t_zero;
      rc(6'h05, 32'h0, epi_pkg::RESP_SLVERR);
      wr(6'h05, 32'hffff_ffff, epi_pkg::RESP_SLVERR);
   endtask

   task automatic t_nmi;
      wr(epi_pkg::IDX_NMICFG, {29'h0, epi_pkg::SENSE_HIGH});
      far_u.drive(16'h0000, 1'b1);
      wt(3);
      chk({31'h0, nmi_irq}, 32'h1);
      wr(epi_pkg::IDX_NMIFLG, 32'h1);
      wt(2);
      chk({31'h0, nmi_irq}, 32'h1);
      far_u.drive(16'h0000, 1'b0);
      wr(epi_pkg::IDX_NMIFLG, 32'h1);
      wt(3);
      chk({31'h0, nmi_irq}, 32'h0);
      // A one-cycle pulse must not pass the filter; a held level must.
      wr(epi_pkg::IDX_NMICFG, {28'h0, 1'b1, epi_pkg::SENSE_RISE});
      far_u.drive(16'h0000, 1'b1);
      wt(1);
      far_u.drive(16'h0000, 1'b0);
      wt(6);
      chk({31'h0, nmi_irq}, 32'h0);
      chk({31'h0, det_req}, 32'h1);
      far_u.drive(16'h0000, 1'b1);
      wt(6);
      chk({31'h0, nmi_irq}, 32'h1);
      wr(epi_pkg::IDX_NMIFLG, 32'h1);
      wt(3);
      chk({31'h0, nmi_irq}, 32'h0);
      far_u.drive(16'h0000, 1'b0);
      wr(epi_pkg::IDX_NMICFG, {29'h0, epi_pkg::SENSE_HIGH});
   endtask

   task automatic t_pins;
      int n;
      far_u.drive(16'h0012, 1'b0);
      // Pin 6 is filtered rising; pins 0..4 use every other sense code.
      wr(epi_pkg::IDX_CFG0, 32'h0905_4321);
      wr(epi_pkg::IDX_EVCTL, 32'hffff);
      wr(epi_pkg::IDX_IENSET, 32'hffff);
      wr(epi_pkg::IDX_WAKE, 32'hffff);
      wr(epi_pkg::IDX_CTRL, 32'h2);
      wt(4);
      chk({31'h0, det_req}, 32'h1);
      far_u.drive(16'h0052, 1'b0);
      wt(1);
      far_u.drive(16'h0012, 1'b0);
      wt(6);
      rc(epi_pkg::IDX_FLAGS, 32'h0);
      far_u.clear_counts();
      far_u.drive(16'h006d, 1'b0);
      n = 0;
      while (irq !== 1'b1 && n < 10) begin
         @(posedge mclk);
         n++;
      end
      chk({31'h0, n <= epi_pkg::LEVEL_LAT_CYC}, 32'h1);
      wt(8);
      rc(epi_pkg::IDX_FLAGS, 32'h005f);
      chk({31'h0, wake}, 32'h1);
      for (int i = 0; i < 16; i++) begin
         chk(far_u.ev_cnt[i], {31'h0, i < 7 && i != 5});
      end
      wr(epi_pkg::IDX_FLAGS, 32'hffff);
      rc(epi_pkg::IDX_FLAGS, 32'h0018);
      far_u.drive(16'h0012, 1'b0);
      wt(8);
      rc(epi_pkg::IDX_FLAGS, 32'h001c);
      wr(epi_pkg::IDX_IENCLR, 32'h001c);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      rc(epi_pkg::IDX_IENSET, 32'hffe3);
      wr(epi_pkg::IDX_IENSET, 32'h0004);
      wt(3);
      chk({31'h0, irq}, 32'h1);
      wr(epi_pkg::IDX_FLAGS, 32'hffff);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      wr(epi_pkg::IDX_CFG0, 32'hffff_ffff);
      rc(epi_pkg::IDX_CFG0, 32'h0905_4321);
      wr(epi_pkg::IDX_CTRL, 32'h2);
      wr(epi_pkg::IDX_CTRL, 32'h0);
      wt(4);
      rc(epi_pkg::IDX_CTRL, 32'h0);
      far_u.drive(16'h006d, 1'b0);
      wt(8);
      rc(epi_pkg::IDX_FLAGS, 32'h0);
   endtask

   task automatic t_soft;
      wr(epi_pkg::IDX_CTRL, 32'h2);
      rc(epi_pkg::IDX_STATUS, 32'h1 << epi_pkg::STATUS_BUSY_BIT);
      wr(epi_pkg::IDX_CTRL, 32'h1);
      wt(4);
      t_zero;
   endtask

   initial begin
      rst_n = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      wt(4);
      rst_n <= 1'b1;
      wt(1);
      t_regs;
      t_nmi;
      t_pins;
      t_soft;
      test_done;
   end
endmodule
